/* File: rtl/add_logic_branch_exec.sv */
// Purpose: executes register and immediate add, and forms, and branch-equal
// Assumes: one instruction per valid cycle, results registered one cycle on
// Notes:   register file lives here, one bank per register set
// Summary of operation
// - any fetch may carry one of five fetch exceptions, reported
// - registers use the current set unless previous set is named
// - register add writes 32-bit sum of both sources, no exception
// - register and, extended opcode 0e, writes bitwise and, no exception
// - register type: opcode 3a low, sources 31..27, 26..22, dest 21..17
// - immediate type: a 31..27, b 26..22, immediate 21..6, opcode 5..0
// - opcode 04 adds sign-extended immediate to first, writes second
// - opcode 2c ands first with immediate in high half, writes second
// - opcode 0c ands first with zero-extended immediate, writes second
// - opcode 26: equal registers branch to pc+4+imm, else pc+4
// - branch displacement is signed bytes from the following instruction
// - taken branch to a non-aligned target raises misaligned exception unless its fetch faulted
`timescale 1ns/1ps
`default_nettype none
`include "alb_cfg.svh"

module add_logic_branch_exec #(
   parameter int unsigned NUM_SETS = 2      // register sets held
) (
   input  wire logic              clk,          // core clock, 100 MHz
   input  wire logic              rst_b,        // async reset, active low
   input  wire alb_pkg::issue_s   issue,        // instruction offered
   input  wire logic [$clog2(NUM_SETS)-1:0] cur_set,  // current set
   input  wire logic [$clog2(NUM_SETS)-1:0] prev_set, // previous set
   output logic                   done,         // result valid, one cycle
   output logic [31:0]            next_pc_out,  // next program counter
   output logic                   wr_en,        // register written
   output logic [4:0]             wr_idx,       // register index written
   output logic [31:0]            wr_data,      // value written
   output logic                   misaligned,   // misaligned branch target
   output alb_pkg::fetch_exc_s    fetch_exc,    // fetch exception reported
   output logic                   unsupported   // word not handled here
);

   localparam int SW = $clog2(NUM_SETS);

   ////////////////////////////////////////////////////////////////////////
   // decode and operand read

   alb_pkg::decoded_s dec;
   alb_pkg::op_e      op;
   logic [SW-1:0]     sel_set;
   logic [31:0]       regs [NUM_SETS][32];
   logic [31:0]       opa;
   logic [31:0]       opb;
   logic [31:0]       sx_imm;
   logic [31:0]       zx_imm;
   logic [31:0]       hi_imm;
   logic [31:0]       seq_pc;
   logic [31:0]       target;
   logic              fetch_fault;
   logic              taken;
   logic              bad_target;

   alb_decode u_decode (
      .word (issue.word),
      .dec  (dec)
   );

   assign op = dec.op;
   assign sel_set = issue.use_prev_set ? prev_set : cur_set;
   assign opa = regs[sel_set][dec.first_source_register];
   assign opb = regs[sel_set][dec.second_register_operand];

   assign sx_imm = {{16{dec.sixteen_bit_immediate_field[15]}},
                    dec.sixteen_bit_immediate_field};
   assign zx_imm = {16'h0000, dec.sixteen_bit_immediate_field};
   assign hi_imm = {dec.sixteen_bit_immediate_field, 16'h0000};
   assign seq_pc = issue.pc + `PC_STEP;
   // displacement bits 1..0 are meant to be clear; checked, not trusted
   assign target = seq_pc + sx_imm;
   assign fetch_fault = |issue.fetch_exc;
   assign taken = (op == alb_pkg::op_beq) && (opa == opb);
   assign bad_target = taken && (target[1:0] != 2'h0);

   ////////////////////////////////////////////////////////////////////////
   // result

   logic        next_wr;
   logic [4:0]  next_idx;
   logic [31:0] next_data;

   always_comb begin
      next_wr   = 1'b0;
      next_idx  = dec.second_register_operand;
      next_data = 32'h00000000;
      unique case (op)
         alb_pkg::op_add: begin
            next_wr   = 1'b1;
            next_idx  = dec.destination_register;
            next_data = opa + opb;
         end
         alb_pkg::op_and: begin
            next_wr   = 1'b1;
            next_idx  = dec.destination_register;
            next_data = opa & opb;
         end
         alb_pkg::op_addi: begin
            next_wr   = 1'b1;
            next_data = opa + sx_imm;
         end
         alb_pkg::op_andhi: begin
            next_wr   = 1'b1;
            next_data = opa & hi_imm;
         end
         alb_pkg::op_andi: begin
            next_wr   = 1'b1;
            next_data = opa & zx_imm;
         end
         alb_pkg::op_beq,
         alb_pkg::op_none: begin
            next_wr = 1'b0;
         end
      endcase
      // a faulting fetch must not write any register; next_pc_out still advances
      if (!issue.valid || fetch_fault) begin
         next_wr = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file; writes land in the same set that was read

   always_ff @(posedge clk) begin
      if (next_wr) begin
         regs[sel_set][next_idx] <= next_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done        <= 1'b0;
         wr_en       <= 1'b0;
         wr_idx      <= 5'h00;
         wr_data     <= 32'h00000000;
      end else begin
         done        <= issue.valid;
         wr_en       <= next_wr;
         wr_idx      <= next_idx;
         wr_data     <= next_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         next_pc_out <= `PC_RESET;
         misaligned  <= 1'b0;
      end else if (issue.valid) begin
         next_pc_out <= taken ? target : seq_pc;
         misaligned  <= bad_target && !fetch_fault;
      end else begin
         misaligned  <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fetch_exc   <= '0;
         unsupported <= 1'b0;
      end else begin
         fetch_exc   <= issue.valid ? issue.fetch_exc : '0;
         unsupported <= issue.valid && !fetch_fault
                        && (op == alb_pkg::op_none);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   // operands are sampled at the issuing edge and the registered answer one
   // edge later; decode checks use literal bit positions, not the macros

   a_add_sum: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && !fetch_fault && op == alb_pkg::op_add
      |=> wr_en && wr_data == $past(opa) + $past(opb)
          && wr_idx == $past(dec.destination_register))
      else $error("register add result wrong");

   a_and_reg: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && !fetch_fault && op == alb_pkg::op_and
      |=> wr_en && wr_data == ($past(opa) & $past(opb))
          && wr_idx == $past(issue.word[21:17]))
      else $error("register and result wrong");

   a_and_decode: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && issue.word[5:0] == 6'h3A && issue.word[16:11] == 6'h0E
      && issue.word[10:6] == 5'h00 |-> op == alb_pkg::op_and)
      else $error("register type and not decoded");

   a_rtype_decode: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && issue.word[5:0] == 6'h3A && issue.word[16:11] == 6'h31
      && issue.word[10:6] == 5'h00 |-> op == alb_pkg::op_add)
      else $error("register type add not decoded");

   a_rtype_spare: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && issue.word[5:0] == 6'h3A && issue.word[10:6] != 5'h00
      |-> op == alb_pkg::op_none)
      else $error("register type with spare bits set accepted");

   a_imm_decode: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && issue.word[5:0] == 6'h04
      |-> op == alb_pkg::op_addi
          && dec.first_source_register == issue.word[31:27]
          && dec.second_register_operand == issue.word[26:22]
          && dec.sixteen_bit_immediate_field == issue.word[21:6])
      else $error("immediate type fields misplaced");

   a_addi_sext: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && !fetch_fault && op == alb_pkg::op_addi
      |=> wr_idx == $past(issue.word[26:22])
          && wr_data == $past(opa)
             + {{16{$past(issue.word[21])}}, $past(issue.word[21:6])})
      else $error("add immediate result wrong");

   a_andhi_high: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && !fetch_fault && op == alb_pkg::op_andhi
      |=> wr_en && wr_data[15:0] == 16'h0000
          && wr_data[31:16] == ($past(opa[31:16]) & $past(issue.word[21:6])))
      else $error("high and immediate wrong");

   a_andi_zero: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && !fetch_fault && op == alb_pkg::op_andi
      |=> wr_en && wr_idx == $past(issue.word[26:22])
          && wr_data == ($past(opa) & {16'h0000, $past(issue.word[21:6])}))
      else $error("and immediate not zero extended");

   a_branch_pc: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && op == alb_pkg::op_beq && opa != opb
      |=> next_pc_out == $past(issue.pc) + 32'h00000004 && !wr_en)
      else $error("untaken branch pc wrong");

   a_pc_hold: assert property (
      @(posedge clk) disable iff (!rst_b)
      !issue.valid |=> $stable(next_pc_out))
      else $error("next pc moved without an issue");

   a_branch_taken: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && op == alb_pkg::op_beq && opa == opb
      |=> next_pc_out == $past(issue.pc) + 32'h00000004 + $past(sx_imm)
          && !wr_en)
      else $error("taken branch pc wrong");

   a_misalign_flag: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && !fetch_fault && taken
      |=> misaligned == (next_pc_out[1:0] != 2'h0))
      else $error("misaligned exception wrong");

   a_fetch_block: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && fetch_fault |=> !wr_en && fetch_exc != '0)
      else $error("faulting fetch committed");

   a_fetch_copy: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid |=> fetch_exc == $past(issue.fetch_exc))
      else $error("fetch exception not reported as offered");

   a_fetch_quiet: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && fetch_fault |=> !misaligned && !unsupported)
      else $error("faulting fetch raised a second exception");

   a_unknown_flag: assert property (
      @(posedge clk) disable iff (!rst_b)
      issue.valid && !fetch_fault && op == alb_pkg::op_none
      |=> unsupported && !wr_en)
      else $error("unknown word not flagged");

   a_cur_set: assert property (
      @(posedge clk) disable iff (!rst_b)
      next_wr && !issue.use_prev_set
      |=> regs[$past(cur_set)][wr_idx] == wr_data)
      else $error("write missed the current set");

   a_prev_set: assert property (
      @(posedge clk) disable iff (!rst_b)
      next_wr && issue.use_prev_set
      |=> regs[$past(prev_set)][wr_idx] == wr_data)
      else $error("write missed the previous set");

   c_add: cover property (@(posedge clk) disable iff (!rst_b)
      issue.valid && op == alb_pkg::op_add);
   c_taken: cover property (@(posedge clk) disable iff (!rst_b)
      issue.valid && taken);
   c_misalign: cover property (@(posedge clk) disable iff (!rst_b)
      misaligned);
   c_fetch: cover property (@(posedge clk) disable iff (!rst_b)
      fetch_exc != '0);
   c_prev_set: cover property (@(posedge clk) disable iff (!rst_b)
      next_wr && issue.use_prev_set);

endmodule
`default_nettype wire

/* File: rtl/alb_cfg.svh */
// Purpose: constants for the add, logic and branch execution slice
// Assumes: 32-bit instruction words, 32 registers per register set
// Notes:   encodings are fixed by the instruction set
`ifndef ALB_CFG_SVH
`define ALB_CFG_SVH

`define OPC_LSB         0
`define OPC_MSB         5
`define XOPC_LSB        11
`define XOPC_MSB        16
`define SHAMT_LSB       6
`define SHAMT_MSB       10
`define RA_LSB          27
`define RA_MSB          31
`define RB_LSB          22
`define RB_MSB          26
`define RC_LSB          17
`define RC_MSB          21
`define IMM_LSB         6
`define IMM_MSB         21

`define OPC_RTYPE       6'h3A
`define OPC_ADDI        6'h04
`define OPC_ANDHI       6'h2C
`define OPC_ANDI        6'h0C
`define OPC_BEQ         6'h26
`define XOPC_ADD        6'h31
`define XOPC_AND        6'h0E

`define PC_STEP         32'h00000004
`define PC_RESET        32'h00000000

`endif

/* File: rtl/alb_pkg.sv */
// Purpose: shared types for the add, logic and branch execution slice
// Assumes: included configuration header supplies the encodings
// Notes:   exception causes are one bit each so several may show at once
`default_nettype none
package alb_pkg;

   typedef enum logic [2:0] {
      op_none,
      op_add,
      op_and,
      op_addi,
      op_andhi,
      op_andi,
      op_beq
   } op_e;

   typedef struct packed {
      logic supervisor_only_addr;
      logic fast_tlb_miss;
      logic double_tlb_miss;
      logic exec_permission;
      logic region_violation;
   } fetch_exc_s;

   typedef struct packed {
      logic        valid;
      logic [31:0] word;
      logic [31:0] pc;
      fetch_exc_s  fetch_exc;
      logic        use_prev_set;
   } issue_s;

   typedef struct packed {
      op_e         op;
      logic [4:0]  first_source_register;
      logic [4:0]  second_register_operand;
      logic [4:0]  destination_register;
      logic [15:0] sixteen_bit_immediate_field;
   } decoded_s;

endpackage
`default_nettype wire

/* File: rtl/alb_decode.sv */
// Purpose: splits an instruction word into operation and fields
// Assumes: word is stable while it is decoded, purely combinational
// Notes:   unknown encodings decode to op_none and are not executed
`timescale 1ns/1ps
`default_nettype none
`include "alb_cfg.svh"

module alb_decode (
   input  wire logic [31:0]      word,   // instruction word
   output alb_pkg::decoded_s     dec     // decoded operation and fields
);

   logic [5:0] opc;
   logic [5:0] xopc;
   logic [4:0] shamt;

   assign opc   = word[`OPC_MSB:`OPC_LSB];
   assign xopc  = word[`XOPC_MSB:`XOPC_LSB];
   assign shamt = word[`SHAMT_MSB:`SHAMT_LSB];

   always_comb begin
      dec.first_source_register       = word[`RA_MSB:`RA_LSB];
      dec.second_register_operand     = word[`RB_MSB:`RB_LSB];
      dec.destination_register        = word[`RC_MSB:`RC_LSB];
      dec.sixteen_bit_immediate_field = word[`IMM_MSB:`IMM_LSB];
      dec.op = alb_pkg::op_none;
      unique case (opc)
         `OPC_RTYPE: begin
            // the spare field must be zero, else the word is not ours
            if (shamt == 5'h00 && xopc == `XOPC_ADD) begin
               dec.op = alb_pkg::op_add;
            end else if (shamt == 5'h00 && xopc == `XOPC_AND) begin
               dec.op = alb_pkg::op_and;
            end
         end
         `OPC_ADDI:  dec.op = alb_pkg::op_addi;
         `OPC_ANDHI: dec.op = alb_pkg::op_andhi;
         `OPC_ANDI:  dec.op = alb_pkg::op_andi;
         `OPC_BEQ:   dec.op = alb_pkg::op_beq;
         default:    dec.op = alb_pkg::op_none;
      endcase
   end

endmodule
`default_nettype wire

/* File: test/tb_add_logic_branch_exec.sv */
// Purpose: self-checking bench for the add, logic and branch slice
// Assumes: one-cycle result latency, register file starts unknown
// Notes:   registers are cleared with andi before use, x and 0 gives 0
`timescale 1ns/1ps
`default_nettype none
`include "alb_cfg.svh"

module tb_add_logic_branch_exec;
   logic                clk;
   logic                rst_b;
   alb_pkg::issue_s     issue;
   logic [0:0]          cur_set;
   logic [0:0]          prev_set;
   logic                done;
   logic [31:0]         next_pc_out;
   logic                wr_en;
   logic [4:0]          wr_idx;
   logic [31:0]         wr_data;
   logic                misaligned;
   alb_pkg::fetch_exc_s fetch_exc;
   logic                unsupported;
   int                  failures;
   int                  tests_run;

   add_logic_branch_exec #(.NUM_SETS(2)) dut (
      .clk(clk), .rst_b(rst_b), .issue(issue), .cur_set(cur_set),
      .prev_set(prev_set), .done(done), .next_pc_out(next_pc_out),
      .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
      .misaligned(misaligned), .fetch_exc(fetch_exc),
      .unsupported(unsupported));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] iw(input logic [5:0] op,
      input logic [4:0] a, input logic [4:0] b, input logic [15:0] imm);
      return {a, b, imm, op};
   endfunction

   function automatic logic [31:0] rw(input logic [5:0] x,
      input logic [4:0] a, input logic [4:0] b, input logic [4:0] c);
      return {a, b, c, x, 5'h00, `OPC_RTYPE};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h",
                  $time, what, seen, exp);
      end
   endtask

   // one issue, a bubble after it, judged just after the edge that takes it
   task automatic exe(input logic [31:0] w, input logic [31:0] pc,
      input logic [4:0] fx, input logic pv, input logic we,
      input logic [4:0] idx, input logic [31:0] d, input logic [31:0] npc,
      input logic mis, input logic uns);
      @(posedge clk);
      issue <= {1'b1, w, pc, fx, pv};
      @(posedge clk);
      issue.valid <= 1'b0;
      #1;
      chk(done, 1'b1, "done");
      chk(wr_en, we, "wr_en");
      if (we) begin
         chk(wr_idx, idx, "wr_idx");
         chk(wr_data, d, "wr_data");
      end
      // pc after an unknown word is left open, so it is not judged
      if (!uns) chk(next_pc_out, npc, "next_pc");
      chk(misaligned, mis, "misaligned");
      chk(unsupported, uns, "unsupported");
      chk(fetch_exc, fx, "fetch_exc");
   endtask

   task automatic ii(input logic [5:0] op, input logic [4:0] a,
      input logic [4:0] b, input logic [15:0] imm, input logic pv,
      input logic [31:0] d);
      exe(iw(op, a, b, imm), 32'h00000040, 5'h00, pv, 1'b1, b, d,
          32'h00000044, 1'b0, 1'b0);
   endtask

   task automatic ri(input logic [5:0] x, input logic [4:0] a,
      input logic [4:0] b, input logic [4:0] c, input logic pv,
      input logic [31:0] d);
      exe(rw(x, a, b, c), 32'h00000040, 5'h00, pv, 1'b1, c, d,
          32'h00000044, 1'b0, 1'b0);
   endtask

   task automatic ld(input logic [4:0] r, input logic [15:0] imm,
                     input logic pv);
      ii(`OPC_ANDI, r, r, 16'h0000, pv, 32'h00000000);
      ii(`OPC_ADDI, r, r, imm, pv, {{16{imm[15]}}, imm});
   endtask

////////////////////////////////////////////////////////////////////////////
   task automatic t_imm();
      ld(5'h01, 16'h8123, 1'b0);
      ld(5'h02, 16'h7FFF, 1'b0);
      ii(`OPC_ANDI, 5'h01, 5'h03, 16'hF0F0, 1'b0, 32'h00008020);
      ii(`OPC_ANDHI, 5'h01, 5'h04, 16'hF0F0, 1'b0, 32'hF0F00000);
      ii(`OPC_ADDI, 5'h02, 5'h1F, 16'hFFFF, 1'b0, 32'h00007FFE);
      $display("t_imm finished");
   endtask

   task automatic t_reg();
      ri(`XOPC_ADD, 5'h01, 5'h02, 5'h05, 1'b0, 32'h00000122);
      ri(`XOPC_AND, 5'h01, 5'h02, 5'h06, 1'b0, 32'h00000123);
      exe(rw(`XOPC_ADD, 5'h01, 5'h02, 5'h07) | 32'h00000040, 32'h00000040,
          5'h00, 1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 1'b0, 1'b1);
      exe(rw(6'h3F, 5'h01, 5'h02, 5'h07), 32'h00000040, 5'h00, 1'b0,
          1'b0, 5'h00, 32'h0, 32'h0, 1'b0, 1'b1);
      exe(iw(6'h3F, 5'h01, 5'h02, 16'h0000), 32'h00000040, 5'h00, 1'b0,
          1'b0, 5'h00, 32'h0, 32'h0, 1'b0, 1'b1);
      $display("t_reg finished");
   endtask

   task automatic t_br();
      exe(iw(`OPC_BEQ, 5'h01, 5'h01, 16'hFFF8), 32'h00000100, 5'h00, 1'b0,
          1'b0, 5'h00, 32'h0, 32'h000000FC, 1'b0, 1'b0);
      exe(iw(`OPC_BEQ, 5'h01, 5'h02, 16'hFFF8), 32'h00000100, 5'h00, 1'b0,
          1'b0, 5'h00, 32'h0, 32'h00000104, 1'b0, 1'b0);
      exe(iw(`OPC_BEQ, 5'h02, 5'h02, 16'h0002), 32'h00000100, 5'h00, 1'b0,
          1'b0, 5'h00, 32'h0, 32'h00000106, 1'b1, 1'b0);
      exe(iw(`OPC_BEQ, 5'h01, 5'h02, 16'h0002), 32'h00000100, 5'h00, 1'b0,
          1'b0, 5'h00, 32'h0, 32'h00000104, 1'b0, 1'b0);
      // word-aligned displacement whose target wraps through zero
      exe(iw(`OPC_BEQ, 5'h01, 5'h01, 16'h7FFC), 32'hFFFF8000, 5'h00, 1'b0,
          1'b0, 5'h00, 32'h0, 32'h00000000, 1'b0, 1'b0);
      $display("t_br finished");
   endtask

   task automatic t_fetch();
      for (int i = 0; i < 5; i++) begin
         exe(iw(`OPC_ADDI, 5'h01, 5'h09, 16'h0001), 32'h00000040,
             5'(5'h10 >> i), 1'b0, 1'b0, 5'h00, 32'h0, 32'h00000044,
             1'b0, 1'b0);
         exe(iw(`OPC_BEQ, 5'h02, 5'h02, 16'h0002), 32'h00000100,
             5'(5'h01 << i), 1'b0, 1'b0, 5'h00, 32'h0, 32'h00000106,
             1'b0, 1'b0);
      end
      $display("t_fetch finished");
   endtask

   // the second issue reads the register that the first one writes
   task automatic t_b2b();
      @(posedge clk);
      issue <= {1'b1, iw(`OPC_ANDI, 5'h01, 5'h0A, 16'hFFFF),
                32'h00000040, 5'h00, 1'b0};
      @(posedge clk);
      issue <= {1'b1, iw(`OPC_ADDI, 5'h0A, 5'h0B, 16'h0001),
                32'h00000044, 5'h00, 1'b0};
      #1;
      chk(wr_data, 32'h00008123, "first of pair");
      @(posedge clk);
      issue.valid <= 1'b0;
      #1;
      chk(wr_data, 32'h00008124, "second of pair");
      chk(next_pc_out, 32'h00000048, "pair pc");
      $display("t_b2b finished");
   endtask

   task automatic t_sets();
      ld(5'h01, 16'h0005, 1'b1);
      ri(`XOPC_ADD, 5'h01, 5'h01, 5'h07, 1'b0, 32'hFFFF0246);
      ri(`XOPC_ADD, 5'h01, 5'h01, 5'h07, 1'b1, 32'h0000000A);
      @(posedge clk);
      cur_set  <= 1'b1;
      prev_set <= 1'b0;
      ri(`XOPC_ADD, 5'h07, 5'h07, 5'h08, 1'b0, 32'h00000014);
      ri(`XOPC_ADD, 5'h07, 5'h07, 5'h08, 1'b1, 32'hFFFE048C);
      $display("t_sets finished");
   endtask

////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // about 80 cycles of traffic, so this only trips on a hang
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      results();
   end

   initial begin
      rst_b     = 1'b0;
      issue     = '0;
      cur_set   = 1'b0;
      prev_set  = 1'b1;
      failures  = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      chk(done, 1'b0, "done in reset");
      chk(next_pc_out, 32'h00000000, "pc in reset");
      rst_b <= 1'b1;
      t_imm();
      t_reg();
      t_br();
      t_fetch();
      t_b2b();
      t_sets();
      results();
   end
endmodule
`default_nettype wire
